// [src/fpd_pkg.sv]
// shared constants and types for the flash protect / page / decode block
//Contract
// - program or erase aimed at a write-locked sector is dropped without effect.
// - verify reads of a locked sector return its stored data.
// - processor may read sector lock bits; its writes to them do nothing.
// - main lock status bit i covers main sector i; 1 means locked.
// - secondary status: bits 3..0 sector locks, bit 7 secured, 6..4 zero.
// - while secured, programmer and scan access to contents is refused.
// - secured flag clears only through a full device erase.
// - processor reads of flash stay working whatever the secured flag.
// - flash reset is one write cycle and returns to read-array mode.
// - flash reset may take milliseconds; processor waits for it.
// - flash reset during program or bulk erase is ignored.
// - flash reset during sector erase aborts it and returns to read-array.
// - 8-bit page register, read/write over data lines, offset E0h.
// - page register outputs clear to zero on reset.
// - page outputs feed the decode terms and are offered to general logic.
// - with power register zero bit 3 clear, arrays idle after 70 ns still.
// - five power-register bits block processor controls from the arrays.
// - decode makes 8 main and 4 secondary selects, three terms each; only term 0 is enabled, so terms 1 and 2 never match.
// - decode makes one select for the 256-byte control register block.
// - decode drives 3 external chip selects, one product term each.
// - decode makes a scan-select enabling scan use of shared port C pins; its only term is disabled, so scan_select_o stays zero.
// - logic arrays see a 64-signal input bus in the documented grouping.
package fpd_pkg;
    localparam int BUS_W = 64;
    localparam int TERMS = 3;
    localparam int N_MAIN = 8;
    localparam int N_SEC = 4;
    localparam int N_ECS = 3;
    // input bus field positions
    localparam int POS_ADDR = 0;
    localparam int POS_CTL = 16;
    localparam int POS_RST = 19;
    localparam int POS_PB = 20;
    localparam int POS_PC = 28;
    localparam int POS_PD = 36;
    localparam int POS_PG = 39;
    localparam int POS_MCA = 47;
    localparam int POS_MCB = 55;
    localparam int POS_RB = 63;
    // control register block offsets
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] OFS_MAIN_LOCK = 8'hC0;
    localparam logic [7:0] OFS_SEC_LOCK = 8'hC2;
    localparam logic [7:0] OFS_PWR0 = 8'hB0;
    localparam logic [7:0] OFS_PWR2 = 8'hB4;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam int PWR0_TURBO_BIT = 3;
    localparam int SEC_SECURE_BIT = 7;
    // processor control lines
    localparam int CTL_WR_N = 0;
    localparam int CTL_RD_N = 1;
    // standby after the input bus stays still
    localparam int IDLE_NS = 70;
    localparam int CLK_PS = 8000;
    localparam int IDLE_CYC = (IDLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // command kinds from the flash command sequencer
    localparam logic [1:0] CMD_RESET = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_SERASE = 2'h2;
    localparam logic [1:0] CMD_BERASE = 2'h3;
    typedef enum logic [2:0] {
        FST_IDLE = 3'h0,
        FST_PROG = 3'h1,
        FST_SERASE = 3'h3,
        FST_BERASE = 3'h2,
        FST_RESETTING = 3'h6
    } fpd_fst_e;
    // default decode: one term per select; index 0..7 main, 8..11 secondary,
    // 12 control block, 13 scan select, 14..16 external selects
    function automatic logic [63:0] dec_mask(input int idx);
        if (idx < N_MAIN) begin
            return (64'h1 << 15) | (64'h7 << POS_PG);
        end else if (idx < N_MAIN + N_SEC) begin
            return 64'h000000000000F000;
        end else if (idx == 13) begin
            return 64'h0000000000000000;
        end else begin
            return 64'h000000000000FF00;
        end
    endfunction
    function automatic logic [63:0] dec_match(input int idx);
        if (idx < N_MAIN) begin
            return (64'h1 << 15) | (64'(idx) << POS_PG);
        end else if (idx < N_MAIN + N_SEC) begin
            return 64'h0000000000004000 | (64'(idx - N_MAIN) << 12);
        end else if (idx == 12) begin
            return 64'h0000000000003F00;
        end else if (idx == 13) begin
            return 64'h0000000000000000;
        end else begin
            return 64'h0000000000003800 | (64'(idx - 14) << 8);
        end
    endfunction
endpackage

// [src/fpd_term_select.sv]
// one decode select: OR of up to TERMS masked-compare product terms
`timescale 1ns/10ps
module fpd_term_select #(
    parameter int TERMS = 3,
    parameter logic [TERMS-1:0] TERM_EN = '0,
    parameter logic [TERMS*64-1:0] MASK = '0,
    parameter logic [TERMS*64-1:0] MATCH = '0
) (
    input wire logic [63:0] bus_i,
    output logic sel_o
);
    always_comb begin
        sel_o = 1'b0;
        for (int t = 0; t < TERMS; t++) begin
            if (TERM_EN[t] && ((bus_i & MASK[t*64 +: 64]) == MATCH[t*64 +: 64])) begin
                sel_o = 1'b1;
            end
        end
    end
endmodule

// [src/fpd_top.sv]
// flash lock status, secured flag, flash reset control, page register and decode array
`timescale 1ns/10ps
module fpd_top
    import fpd_pkg::*;
#(
    parameter int IDLE_COUNT = fpd_pkg::IDLE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // processor bus pins
    input wire logic [15:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic [2:0] processor_controls_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // general ports seen by the logic arrays
    input wire logic [7:0] port_b_i,
    input wire logic [7:0] port_c_i,
    input wire logic [2:0] port_d_i,
    input wire logic [7:0] macrocell_group_a_feedback_i,
    input wire logic [7:0] macrocell_group_b_feedback_i,
    // nonvolatile lock and secured cells
    input wire logic [7:0] main_lock_nv_i,
    input wire logic [3:0] sec_lock_nv_i,
    input wire logic secure_nv_i,
    input wire logic full_device_erase_i,
    input wire logic programmer_req_i,
    output logic programmer_grant_o,
    // flash command sequencer, one pulse on the final write of a command
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_kind_i,
    input wire logic array_done_i,
    output logic array_go_o,
    output logic [1:0] array_kind_o,
    output logic [11:0] array_sectors_o,
    output logic array_reset_o,
    output logic array_abort_o,
    output logic ready_busy_o,
    // decode array outputs
    output logic [7:0] main_sector_selects_o,
    output logic [3:0] secondary_sector_selects_o,
    output logic ctrl_block_select_o,
    output logic scan_select_o,
    output logic [2:0] external_chip_selects_o,
    output logic [7:0] page_outputs_o,
    output logic [63:0] logic_input_bus_o,
    output logic array_standby_o
);
    import fpd_pkg::*;

    typedef struct packed {
        logic [15:0] a1;
        logic [15:0] a2;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [2:0] c1;
        logic [2:0] c2;
        logic [7:0] pb1;
        logic [7:0] pb2;
        logic [7:0] pc1;
        logic [7:0] pc2;
        logic [2:0] pd1;
        logic [2:0] pd2;
        logic wr_prev;
        logic in_reset;
        logic [7:0] page;
        logic [7:0] pwr0;
        logic [7:0] pwr2;
        logic [7:0] rdata;
        logic rd_oe;
        logic [7:0] fs;
        logic [3:0] bs;
        logic csio;
        logic scan;
        logic [2:0] ecs;
        logic [63:0] bus_prev;
        logic [7:0] idle_cnt;
        logic standby;
        logic loaded;
        logic secure;
        logic [7:0] main_lock;
        logic [3:0] sec_lock;
        fpd_fst_e st;
        logic go;
        logic [1:0] kind;
        logic [11:0] sect;
        logic arr_reset;
        logic arr_abort;
    } fpd_state_s;

    fpd_state_s r;
    fpd_state_s next_r;

    logic [63:0] bus;
    logic [16:0] dec;
    logic [2:0] ctl_in;
    logic [2:0] pd_in;
    logic [11:0] hit;
    logic [11:0] locks;

    // blocked controls enter the arrays as constant zero; the register
    // access path still uses the real strobes
    always_comb begin
        ctl_in = r.c2 & ~r.pwr2[2:0];
        pd_in = {r.pd2[2], r.pd2[1:0] & ~r.pwr2[4:3]};
    end

    // the 64-signal input bus shared by both arrays
    always_comb begin
        bus = '0;
        bus[POS_ADDR +: 16] = r.a2;
        bus[POS_CTL +: 3] = ctl_in;
        bus[POS_RST] = r.in_reset;
        bus[POS_PB +: 8] = r.pb2;
        bus[POS_PC +: 8] = r.pc2;
        bus[POS_PD +: 3] = pd_in;
        bus[POS_PG +: 8] = r.page;
        bus[POS_MCA +: 8] = macrocell_group_a_feedback_i;
        bus[POS_MCB +: 8] = macrocell_group_b_feedback_i;
        bus[POS_RB] = (r.st != FST_IDLE);
    end

    // 8 main, 4 secondary, control block, scan select, 3 external selects
    genvar g;
    generate
        for (g = 0; g < 17; g++) begin : g_sel
            // single-term selects get exactly 64-bit vectors, no silent truncation
            if (g >= 12) begin : g_one
                fpd_term_select #(
                    .TERMS(1),
                    .TERM_EN((g == 13) ? 1'b0 : 1'b1),
                    .MASK(dec_mask(g)),
                    .MATCH(dec_match(g))
                ) u_sel (
                    .bus_i(bus),
                    .sel_o(dec[g])
                );
            end else begin : g_three
                fpd_term_select #(
                    .TERMS(TERMS),
                    .TERM_EN(3'h1),
                    .MASK({128'h0, dec_mask(g)}),
                    .MATCH({128'h0, dec_match(g)})
                ) u_sel (
                    .bus_i(bus),
                    .sel_o(dec[g])
                );
            end
        end
    endgenerate

    always_comb begin
        hit = {r.bs, r.fs};
        locks = {r.sec_lock, r.main_lock};
    end

    always_comb begin
        logic wr_done;
        logic reg_hit;
        logic [7:0] ofs;
        logic [11:0] arr_all;
        wr_done = 1'b0;
        reg_hit = 1'b0;
        ofs = 8'h00;
        arr_all = 12'h000;
        next_r = r;
        // pin inputs pass two flops before use
        next_r.a1 = addr_i;
        next_r.a2 = r.a1;
        next_r.d1 = data_i;
        next_r.d2 = r.d1;
        next_r.c1 = processor_controls_i;
        next_r.c2 = r.c1;
        next_r.pb1 = port_b_i;
        next_r.pb2 = r.pb1;
        next_r.pc1 = port_c_i;
        next_r.pc2 = r.pc1;
        next_r.pd1 = port_d_i;
        next_r.pd2 = r.pd1;
        next_r.in_reset = 1'b0;
        next_r.wr_prev = r.c2[CTL_WR_N];
        next_r.go = 1'b0;
        next_r.arr_reset = 1'b0;
        next_r.arr_abort = 1'b0;

        // lock cells are mirrored; there is no write path into them
        next_r.main_lock = main_lock_nv_i;
        next_r.sec_lock = sec_lock_nv_i;
        next_r.loaded = 1'b1;
        if (!r.loaded) begin
            next_r.secure = secure_nv_i;
        end else if (full_device_erase_i) begin
            next_r.secure = 1'b0;
        end

        // standby: turbo off and bus still for the idle time; selects hold
        if (bus != r.bus_prev) begin
            next_r.idle_cnt = 8'h00;
            next_r.standby = 1'b0;
        end else if (r.idle_cnt < 8'(IDLE_COUNT)) begin
            next_r.idle_cnt = r.idle_cnt + 8'h01;
        end else begin
            next_r.standby = ~r.pwr0[PWR0_TURBO_BIT];
        end
        next_r.bus_prev = bus;
        // a bus change wakes the selects on the same edge, so latency stays fixed
        if (!r.standby || bus != r.bus_prev) begin
            next_r.fs = dec[7:0];
            next_r.bs = dec[11:8];
            next_r.csio = dec[12];
            next_r.scan = dec[13];
            next_r.ecs = dec[16:14];
        end

        // register block: write lands on the trailing edge of the write strobe
        reg_hit = r.csio;
        ofs = r.a2[7:0];
        wr_done = r.c2[CTL_WR_N] && !r.wr_prev;
        if (wr_done && reg_hit) begin
            case (ofs)
                OFS_PAGE: next_r.page = r.d2;
                OFS_PWR0: next_r.pwr0 = r.d2;
                OFS_PWR2: next_r.pwr2 = r.d2;
                default: next_r.page = r.page;  // lock registers ignore writes
            endcase
        end
        next_r.rd_oe = reg_hit && !r.c2[CTL_RD_N];
        case (ofs)
            OFS_PAGE: next_r.rdata = r.page;
            OFS_MAIN_LOCK: next_r.rdata = r.main_lock;
            OFS_SEC_LOCK: next_r.rdata = {r.secure, 3'h0, r.sec_lock};
            OFS_PWR0: next_r.rdata = r.pwr0;
            OFS_PWR2: next_r.rdata = r.pwr2;
            default: next_r.rdata = 8'h00;
        endcase

        // flash command control; array reads are never gated here
        arr_all = (|r.fs) ? 12'h0FF : 12'hF00;
        case (r.st)
            FST_IDLE: begin
                if (cmd_valid_i) begin
                    if (cmd_kind_i == CMD_RESET) begin
                        next_r.arr_reset = 1'b1;
                        next_r.st = FST_RESETTING;
                    end else if (cmd_kind_i == CMD_BERASE) begin
                        if ((|hit) && !(|(arr_all & locks))) begin
                            next_r.go = 1'b1;
                            next_r.kind = cmd_kind_i;
                            next_r.sect = arr_all;
                            next_r.st = FST_BERASE;
                        end
                    end else if ((|hit) && !(|(hit & locks))) begin
                        next_r.go = 1'b1;
                        next_r.kind = cmd_kind_i;
                        next_r.sect = hit;
                        next_r.st = (cmd_kind_i == CMD_PROG) ? FST_PROG : FST_SERASE;
                    end
                end
            end
            FST_PROG, FST_BERASE: begin
                // a reset arriving here is dropped
                if (array_done_i) begin
                    next_r.st = FST_IDLE;
                end
            end
            FST_SERASE: begin
                if (cmd_valid_i && cmd_kind_i == CMD_RESET) begin
                    next_r.arr_abort = 1'b1;
                    next_r.st = FST_RESETTING;
                end else if (array_done_i) begin
                    next_r.st = FST_IDLE;
                end
            end
            FST_RESETTING: begin
                // busy stays up for however long the array needs
                if (array_done_i) begin
                    next_r.st = FST_IDLE;
                end
            end
            default: next_r.st = FST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.in_reset <= 1'b1;
            r.wr_prev <= 1'b1;
            r.c1 <= 3'h7;
            r.c2 <= 3'h7;
            r.page <= PAGE_RST;
            r.pwr0 <= PWR_RST;
            r.pwr2 <= PWR_RST;
            r.st <= FST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // verify reads of locked sectors go through the normal array read path
    assign main_sector_selects_o = r.fs;
    assign secondary_sector_selects_o = r.bs;
    assign ctrl_block_select_o = r.csio;
    assign scan_select_o = r.scan;
    assign external_chip_selects_o = r.ecs;
    assign page_outputs_o = r.page;
    assign logic_input_bus_o = r.bus_prev;
    assign array_standby_o = r.standby;
    assign data_o = r.rdata;
    assign data_oe_o = r.rd_oe;
    assign programmer_grant_o = programmer_req_i && r.loaded && !r.secure;
    assign array_go_o = r.go;
    assign array_kind_o = r.kind;
    assign array_sectors_o = r.sect;
    assign array_reset_o = r.arr_reset;
    assign array_abort_o = r.arr_abort;
    assign ready_busy_o = (r.st != FST_IDLE);
endmodule

// [verif/fpd_top_checker.sv]
// port assertions for the flash protect, page and decode block
`timescale 1ns/10ps
module fpd_top_checker
    import fpd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] processor_controls_i,
    input wire logic [7:0] main_lock_nv_i,
    input wire logic [3:0] sec_lock_nv_i,
    input wire logic programmer_req_i,
    input wire logic programmer_grant_o,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_kind_i,
    input wire logic array_done_i,
    input wire logic array_go_o,
    input wire logic [1:0] array_kind_o,
    input wire logic [11:0] array_sectors_o,
    input wire logic array_reset_o,
    input wire logic array_abort_o,
    input wire logic ready_busy_o,
    input wire logic [7:0] page_outputs_o
);
    logic in_serase;
    logic in_run;
    logic [3:0] wr_age;
    logic rst_cmd;
    assign rst_cmd = cmd_valid_i && cmd_kind_i == CMD_RESET && !array_done_i;
    // tracks which operation the array runs, since array_kind_o is stale once idle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_serase <= 1'b0;
            in_run <= 1'b0;
            wr_age <= 4'hF;
        end else begin
            in_serase <= array_go_o ? array_kind_o == CMD_SERASE
                : in_serase && !array_abort_o && !array_done_i;
            in_run <= array_go_o ? array_kind_o != CMD_SERASE : in_run && !array_done_i;
            wr_age <= !processor_controls_i[0] ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_grant_needs_req: assert property (programmer_grant_o |-> programmer_req_i)
        else $error("grant without request");
    a_go_unlocked_only: assert property (array_go_o && array_kind_o != CMD_BERASE
        |-> (array_sectors_o & $past({sec_lock_nv_i, main_lock_nv_i})) == 12'h000)
        else $error("operation started on a locked sector");
    a_go_from_cmd: assert property (array_go_o |-> $past(cmd_valid_i)
        && $past(cmd_kind_i) != CMD_RESET && array_kind_o == $past(cmd_kind_i))
        else $error("start without matching command");
    a_go_single: assert property (array_go_o |-> ready_busy_o ##1 !array_go_o)
        else $error("start pulse wrong");
    a_reset_ignored: assert property (in_run && rst_cmd
        |=> ready_busy_o && !array_abort_o && !array_reset_o)
        else $error("flash reset acted during program or bulk erase");
    a_serase_abort: assert property (in_serase && rst_cmd |=> array_abort_o)
        else $error("flash reset did not abort sector erase");
    a_idle_reset: assert property (!ready_busy_o && rst_cmd |=> array_reset_o && ready_busy_o)
        else $error("single write flash reset not taken");
    a_reset_pulse: assert property ((array_reset_o || array_abort_o)
        |=> !array_reset_o && !array_abort_o)
        else $error("reset pulse too long");
    a_page_by_write: assert property ($changed(page_outputs_o) |-> wr_age < 4'h8)
        else $error("page changed without a write");
    c_abort: cover property (array_abort_o);
    c_bulk: cover property (array_go_o && array_kind_o == CMD_BERASE);
    c_page: cover property ($changed(page_outputs_o));
endmodule

// [verif/fpd_dsp_model.sv]
// processor bus model: byte cycles on the external memory port
`timescale 1ns/10ps
module fpd_dsp_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i,
    output logic [15:0] addr_o,
    output logic [7:0] data_o,
    output logic [2:0] ctl_o
);
    initial begin
        addr_o = 16'h0000;
        data_o = 8'hFF;
        ctl_o = 3'h7;
    end
    task automatic bus_addr(input logic [15:0] a);
        @(posedge clk_i);
        addr_o <= a;
        repeat (4) @(posedge clk_i);
    endtask
    // strobes and address held 4 clocks: the pins pass two sync flops first
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        data_o <= d;
        ctl_o[0] <= 1'b0;
        repeat (4) @(posedge clk_i);
        ctl_o[0] <= 1'b1;
        repeat (4) @(posedge clk_i);
        data_o <= ~d;
    endtask
    task automatic bus_read(input logic [15:0] a, output logic [8:0] r);
        @(posedge clk_i);
        addr_o <= a;
        ctl_o[1] <= 1'b0;
        repeat (6) @(posedge clk_i);
        r = {rdata_oe_i, rdata_i};
        ctl_o[1] <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// [verif/fpd_top_tb.sv]
// self-checking bench for the flash protect, page and decode block
`timescale 1ns/10ps
module fpd_top_tb;
    import fpd_pkg::*;
    logic clk = 1'b0, rst = 1'b1, full_erase = 1'b0, secure_nv = 1'b0, prog_req = 1'b0;
    logic cmd_valid = 1'b0, done = 1'b0;
    logic [1:0] cmd_kind = 2'h0;
    logic [7:0] main_lock = 8'h05;
    logic [7:0] pb = 8'h5A, mca = 8'h81;
    logic [2:0] pd = 3'h5;
    logic [3:0] sec_lock = 4'h2;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, msel, page;
    logic [2:0] ctl, ecs;
    logic rdata_oe, grant, go, arst, abort, busy, csel, jsel, stby;
    logic [1:0] kind;
    logic [11:0] sectors;
    logic [3:0] ssel;
    logic [63:0] ibus;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    always #4 clk = ~clk;
    fpd_top i_fpd_top (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .data_i(wdata),
        .processor_controls_i(ctl), .data_o(rdata), .data_oe_o(rdata_oe), .port_b_i(pb),
        .port_c_i(8'h3C), .port_d_i(pd), .macrocell_group_a_feedback_i(mca),
        .macrocell_group_b_feedback_i(8'h42), .main_lock_nv_i(main_lock),
        .sec_lock_nv_i(sec_lock), .secure_nv_i(secure_nv), .full_device_erase_i(full_erase),
        .programmer_req_i(prog_req), .programmer_grant_o(grant), .cmd_valid_i(cmd_valid),
        .cmd_kind_i(cmd_kind), .array_done_i(done), .array_go_o(go), .array_kind_o(kind),
        .array_sectors_o(sectors), .array_reset_o(arst), .array_abort_o(abort),
        .ready_busy_o(busy), .main_sector_selects_o(msel), .secondary_sector_selects_o(ssel),
        .ctrl_block_select_o(csel), .scan_select_o(jsel), .external_chip_selects_o(ecs),
        .page_outputs_o(page), .logic_input_bus_o(ibus), .array_standby_o(stby));
    fpd_dsp_model i_dsp (.clk_i(clk), .rdata_i(rdata), .rdata_oe_i(rdata_oe), .addr_o(addr),
        .data_o(wdata), .ctl_o(ctl));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic do_reset(input logic sec);
        @(posedge clk);
        secure_nv <= sec;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // command pulse; the answer is taken 1 ns after the accepting edge
    task automatic send_cmd(input logic [1:0] k, output logic [2:0] r);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
        r = {go, arst, abort};
    endtask
    task automatic finish_op;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        check("idle again", busy, 1'b0);
    endtask
    task automatic t_page;
        logic [8:0] r;
        check("page at reset", page, 8'h00);
        i_dsp.bus_write(16'h3FE0, 8'hA5);
        check("page out", page, 8'hA5);
        i_dsp.bus_read(16'h3FE0, r);
        check("page read", r, 9'h1A5);
        i_dsp.bus_write(16'h3FC0, 8'h00);
        i_dsp.bus_read(16'h3FC0, r);
        check("main locks", r[7:0], main_lock);
        i_dsp.bus_read(16'h3FC2, r);
        check("second locks", r[7:0], {secure_nv, 3'h0, sec_lock});
        i_dsp.bus_read(16'h3F7F, r);
        check("unmapped read", r[7:0], 8'h00);
        do_reset(1'b0);
        check("page cleared", page, 8'h00);
    endtask
    task automatic t_decode;
        for (int j = 0; j < 4; j++) begin
            i_dsp.bus_addr(16'h4000 + 16'(j) * 16'h1000);
            check("second sel", {msel, ssel}, 16'h1 << j);
        end
        for (int j = 0; j < 3; j++) begin
            i_dsp.bus_addr(16'h3800 + 16'(j) * 16'h0100);
            check("ext sel", ecs, 16'h1 << j);
        end
        i_dsp.bus_addr(16'h3F10);
        check("ctrl and scan sel", {csel, jsel}, 2'h2);
        i_dsp.bus_write(16'h3FE0, 8'h03);
        i_dsp.bus_addr(16'h8123);
        check("paged main sel", msel, 8'h08);
        repeat (14) @(posedge clk);
        #1;
        check("standby", stby, 1'b1);
        check("bus addr", ibus[15:0], 16'h8123);
        check("bus ports", {ibus[POS_PB +: 8], ibus[POS_MCA +: 8]}, 16'h5A81);
        check("bus page", ibus[POS_PG +: 8], 8'h03);
        i_dsp.bus_write(16'h3FB4, 8'h09);
        pb <= 8'hC3;
        pd <= 3'h7;
        mca <= 8'h7E;
        repeat (4) @(posedge clk);
        #1;
        check("bus ports new", {ibus[POS_PB +: 8], ibus[POS_MCA +: 8]}, 16'hC37E);
        check("blocked ctl", {ibus[POS_CTL], ibus[POS_PD +: 3]}, 4'h6);
        i_dsp.bus_write(16'h3FB0, 8'h08);
        repeat (14) @(posedge clk);
        #1;
        check("turbo awake", stby, 1'b0);
    endtask
    task automatic t_cmd;
        logic [2:0] r;
        i_dsp.bus_write(16'h3FE0, 8'h00);
        i_dsp.bus_addr(16'h8000);
        send_cmd(CMD_PROG, r);
        check("locked program", {r, busy}, 4'h0);
        i_dsp.bus_write(16'h3FE0, 8'h01);
        i_dsp.bus_addr(16'h8000);
        send_cmd(CMD_PROG, r);
        check("program go", {r, busy, sectors}, {4'h9, 12'h002});
        send_cmd(CMD_RESET, r);
        check("reset in program", {r, busy}, 4'h1);
        finish_op();
        send_cmd(CMD_SERASE, r);
        check("erase go", {r, busy, kind}, {4'h9, CMD_SERASE});
        send_cmd(CMD_RESET, r);
        check("erase abort", {r, busy}, 4'h3);
        finish_op();
        send_cmd(CMD_BERASE, r);
        check("locked bulk", {r, busy}, 4'h0);
        sec_lock <= 4'h0;
        i_dsp.bus_addr(16'h4000);
        send_cmd(CMD_BERASE, r);
        check("bulk go", {r, busy, sectors}, {4'h9, 12'hF00});
        send_cmd(CMD_RESET, r);
        check("reset in bulk", {r, busy}, 4'h1);
        finish_op();
        send_cmd(CMD_RESET, r);
        check("idle reset", {r, busy}, 4'h5);
        finish_op();
    endtask
    task automatic t_secure;
        logic [8:0] r;
        @(posedge clk);
        prog_req <= 1'b1;
        @(posedge clk);
        #1;
        check("grant open", grant, 1'b1);
        do_reset(1'b1);
        check("grant secured", grant, 1'b0);
        i_dsp.bus_read(16'h3FC2, r);
        check("secure flag", r, 9'h180);
        @(posedge clk);
        full_erase <= 1'b1;
        @(posedge clk);
        full_erase <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("grant after erase", grant, 1'b1);
    endtask
    initial begin
        do_reset(1'b0);
        t_page();
        t_decode();
        t_cmd();
        t_secure();
        summarize();
    end
endmodule
bind fpd_top fpd_top_checker i_fpd_top_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .processor_controls_i(processor_controls_i), .main_lock_nv_i(main_lock_nv_i),
    .sec_lock_nv_i(sec_lock_nv_i), .programmer_req_i(programmer_req_i),
    .programmer_grant_o(programmer_grant_o), .cmd_valid_i(cmd_valid_i),
    .cmd_kind_i(cmd_kind_i), .array_done_i(array_done_i), .array_go_o(array_go_o),
    .array_kind_o(array_kind_o), .array_sectors_o(array_sectors_o),
    .array_reset_o(array_reset_o), .array_abort_o(array_abort_o),
    .ready_busy_o(ready_busy_o), .page_outputs_o(page_outputs_o));
